/* design/ufc_defines.svh */
// Offsets, field positions, reset values and trigger levels of the FIFO control
`ifndef UFC_DEFINES_SVH
`define UFC_DEFINES_SVH

`define UFC_ADDR_W          8
`define UFC_FIFO_DEPTH      32
`define UFC_OFF_FIFO_CTRL   8'h00
`define UFC_OFF_TX_DATA     8'h04
`define UFC_OFF_RX_DATA     8'h08
`define UFC_OFF_STATUS      8'h0C

`define UFC_FCR_ENABLE      0
`define UFC_FCR_RX_FLUSH    1
`define UFC_FCR_TX_FLUSH    2
`define UFC_FCR_DMA_MODE    3
`define UFC_FCR_TX_THR_LSB  4
`define UFC_FCR_RX_THR_LSB  6
`define UFC_FCR_RESET       6'h00

`define UFC_RX_TRIG_00      6'h08
`define UFC_RX_TRIG_01      6'h10
`define UFC_RX_TRIG_10      6'h18
`define UFC_RX_TRIG_11      6'h1C
`define UFC_TX_TRIG_00      6'h10
`define UFC_TX_TRIG_01      6'h08
`define UFC_TX_TRIG_10      6'h18
`define UFC_TX_TRIG_11      6'h1E

`define UFC_ST_TX_CNT_LSB   8
`define UFC_ST_TX_REQ_N     16
`define UFC_ST_RX_REQ_N     17
`define UFC_ST_RX_IRQ       18
`define UFC_ST_TX_IRQ       19

`define UFC_RESP_OKAY       2'h0
`define UFC_RESP_DECERR     2'h3

`endif

/* design/ufc_pkg.sv */
// Types shared by the FIFO control block
`default_nettype none
package ufc_pkg;

    typedef struct packed {
        logic [1:0] rx_thr;
        logic [1:0] tx_thr;
        logic       dma_mode;
        logic       fifo_en;
    } ufc_fcr_t;

    typedef enum logic [1:0] {
        RD_IDLE,
        RD_WAIT,
        RD_DATA,
        RD_RESP
    } ufc_rd_state_t;

endpackage
`default_nettype wire

/* design/ufc_mem.sv */
// Byte-wide queue storage with a registered read port
`timescale 1ns/100ps
`default_nettype none
module ufc_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int AW    = $clog2(DEPTH)
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    // Write port
    input  wire logic             i_wr_en,
    input  wire logic [AW-1:0]    i_wr_addr,
    input  wire logic [WIDTH-1:0] i_wr_data,
    // Read port
    input  wire logic [AW-1:0]    i_rd_addr,
    output logic      [WIDTH-1:0] o_rd_data
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge i_clk) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rd_data <= '0;
        end else begin
            o_rd_data <= mem[i_rd_addr];
        end
    end

endmodule // ufc_mem
`default_nettype wire

/* design/ufc_top.sv */
// FIFO control, flush, trigger levels and request pins behind AXI4-Lite
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ufc_defines.svh"
module ufc_top #(
    parameter int DEPTH = `UFC_FIFO_DEPTH,
    parameter int AW    = $clog2(DEPTH),
    parameter int CW    = $clog2(DEPTH + 1)
) (
    // Clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_rst_b,
    // AXI4-Lite write channels
    input  wire logic                   i_awvalid,
    output logic                        o_awready,
    input  wire logic [`UFC_ADDR_W-1:0] i_awaddr,
    input  wire logic                   i_wvalid,
    output logic                        o_wready,
    input  wire logic [31:0]            i_wdata,
    input  wire logic [3:0]             i_wstrb,
    output logic                        o_bvalid,
    input  wire logic                   i_bready,
    output logic      [1:0]             o_bresp,
    // AXI4-Lite read channels
    input  wire logic                   i_arvalid,
    output logic                        o_arready,
    input  wire logic [`UFC_ADDR_W-1:0] i_araddr,
    output logic                        o_rvalid,
    input  wire logic                   i_rready,
    output logic      [31:0]            o_rdata,
    output logic      [1:0]             o_rresp,
    // Transmit shifter side
    output logic                        o_tx_valid,
    output logic      [7:0]             o_tx_data,
    input  wire logic                   i_tx_take,
    // Receive shifter side
    input  wire logic                   i_rx_valid,
    input  wire logic [7:0]             i_rx_data,
    output logic                        o_rx_ready,
    input  wire logic                   i_rx_timeout,
    // Request pins and interrupt conditions
    output logic                        o_tx_request_n,
    output logic                        o_rx_request_n,
    output logic                        o_rx_data_irq,
    output logic                        o_tx_empty_irq,
    output logic                        o_fifo_enabled
);

    // Trigger levels up to 30 need at least 32 entries
    generate
        if (DEPTH < 32 || DEPTH > 128 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
            $error("ufc_top: DEPTH must be a power of two from 32 to 128");
        end
    endgenerate

    function automatic logic [CW-1:0] rx_trig_level(input logic [1:0] code);
        case (code)
            2'b00:   rx_trig_level = CW'(`UFC_RX_TRIG_00);
            2'b01:   rx_trig_level = CW'(`UFC_RX_TRIG_01);
            2'b10:   rx_trig_level = CW'(`UFC_RX_TRIG_10);
            default: rx_trig_level = CW'(`UFC_RX_TRIG_11);
        endcase
    endfunction

    function automatic logic [CW-1:0] tx_trig_level(input logic [1:0] code);
        case (code)
            2'b00:   tx_trig_level = CW'(`UFC_TX_TRIG_00);
            2'b01:   tx_trig_level = CW'(`UFC_TX_TRIG_01);
            2'b10:   tx_trig_level = CW'(`UFC_TX_TRIG_10);
            default: tx_trig_level = CW'(`UFC_TX_TRIG_11);
        endcase
    endfunction

    function automatic logic addr_hit(input logic [`UFC_ADDR_W-1:0] a,
                                      input logic [7:0] off);
        addr_hit = (a[7:2] == off[7:2]);
    endfunction

    // Next count from flush, push and pop
    function automatic logic [CW-1:0] next_count(input logic [CW-1:0] c,
                                                 input logic flush,
                                                 input logic push,
                                                 input logic pop);
        if (flush) begin
            next_count = '0;
        end else if (push && !pop) begin
            next_count = c + CW'(1);
        end else if (pop && !push) begin
            next_count = c - CW'(1);
        end else begin
            next_count = c;
        end
    endfunction

    ufc_pkg::ufc_fcr_t       fifo_control;
    ufc_pkg::ufc_rd_state_t  rd_state;
    logic                    aw_got;
    logic                    w_got;
    logic [`UFC_ADDR_W-1:0]  wr_addr;
    logic [31:0]             wr_data;
    logic                    wr_lane0;
    logic [`UFC_ADDR_W-1:0]  rd_addr;
    logic                    rx_hit;
    logic [AW-1:0]           tx_wr_ptr;
    logic [AW-1:0]           tx_rd_ptr;
    logic [CW-1:0]           tx_count;
    logic [AW-1:0]           rx_wr_ptr;
    logic [AW-1:0]           rx_rd_ptr;
    logic [CW-1:0]           rx_count;
    logic                    tx_fresh;
    logic                    rx_req_held;
    logic [7:0]              tx_head;
    logic [7:0]              rx_head;

    logic                    wr_go;
    logic                    wr_fcr;
    logic                    wr_mapped;
    logic                    en_change;
    logic                    tx_flush;
    logic                    rx_flush;
    logic                    mode1;
    logic [CW-1:0]           cap;
    logic                    tx_full;
    logic                    rx_full;
    logic                    tx_push;
    logic                    tx_pop;
    logic                    rx_push;
    logic                    rx_pop;
    logic [CW-1:0]           rx_trig;
    logic [CW-1:0]           tx_trig;
    logic                    rx_req_set;
    logic [31:0]             rd_mux;
    logic                    rd_mapped;

    // Write channel: address and data taken in either order
    assign o_awready = !aw_got && !o_bvalid;
    assign o_wready  = !w_got && !o_bvalid;
    assign wr_go     = aw_got && w_got && !o_bvalid;
    assign wr_fcr    = wr_go && wr_lane0 &&
                       addr_hit(wr_addr, `UFC_OFF_FIFO_CTRL);
    assign wr_mapped = addr_hit(wr_addr, `UFC_OFF_FIFO_CTRL) ||
                       addr_hit(wr_addr, `UFC_OFF_TX_DATA) ||
                       addr_hit(wr_addr, `UFC_OFF_RX_DATA) ||
                       addr_hit(wr_addr, `UFC_OFF_STATUS);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            aw_got  <= 1'b0;
            wr_addr <= '0;
        end else if (o_awready && i_awvalid) begin
            aw_got  <= 1'b1;
            wr_addr <= i_awaddr;
        end else if (wr_go) begin
            aw_got  <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            w_got    <= 1'b0;
            wr_data  <= '0;
            wr_lane0 <= 1'b0;
        end else if (o_wready && i_wvalid) begin
            w_got    <= 1'b1;
            wr_data  <= i_wdata;
            wr_lane0 <= i_wstrb[0];
        end else if (wr_go) begin
            w_got    <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_bvalid <= 1'b0;
            o_bresp  <= `UFC_RESP_OKAY;
        end else if (wr_go) begin
            o_bvalid <= 1'b1;
            o_bresp  <= wr_mapped ? `UFC_RESP_OKAY : `UFC_RESP_DECERR;
        end else if (i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // Control register; other fields only load when the write keeps enable
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fifo_control <= `UFC_FCR_RESET;
        end else if (wr_fcr) begin
            if (wr_data[`UFC_FCR_ENABLE]) begin
                fifo_control.rx_thr   <= wr_data[`UFC_FCR_RX_THR_LSB +: 2];
                fifo_control.tx_thr   <= wr_data[`UFC_FCR_TX_THR_LSB +: 2];
                fifo_control.dma_mode <= wr_data[`UFC_FCR_DMA_MODE];
                fifo_control.fifo_en  <= 1'b1;
            end else begin
                fifo_control.fifo_en  <= 1'b0;
            end
        end
    end

    // Switching the queues on or off drops stale bytes as a flush does
    assign en_change = wr_fcr && (wr_data[`UFC_FCR_ENABLE] != fifo_control.fifo_en);
    assign tx_flush  = en_change || (wr_fcr && wr_data[`UFC_FCR_ENABLE] &&
                       wr_data[`UFC_FCR_TX_FLUSH]);
    assign rx_flush  = en_change || (wr_fcr && wr_data[`UFC_FCR_ENABLE] &&
                       wr_data[`UFC_FCR_RX_FLUSH]);

    // Without the queues each side behaves as a one-byte holding stage
    assign cap      = fifo_control.fifo_en ? CW'(DEPTH) : CW'(1);
    assign mode1    = fifo_control.fifo_en && fifo_control.dma_mode;
    assign tx_full  = (tx_count >= cap);
    assign rx_full  = (rx_count >= cap);
    assign rx_trig  = rx_trig_level(fifo_control.rx_thr);
    assign tx_trig  = tx_trig_level(fifo_control.tx_thr);

    assign tx_push  = wr_go && wr_lane0 && !tx_full && !tx_flush &&
                      addr_hit(wr_addr, `UFC_OFF_TX_DATA);
    assign tx_pop   = o_tx_valid && i_tx_take && !tx_flush;
    assign o_rx_ready = !rx_full && !rx_flush;
    assign rx_push  = i_rx_valid && o_rx_ready;
    assign rx_pop   = (rd_state == ufc_pkg::RD_DATA) && rx_hit &&
                      (rx_count != '0) && !rx_flush &&
                      addr_hit(rd_addr, `UFC_OFF_RX_DATA);

    // Transmit queue pointers and count
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_wr_ptr <= '0;
            tx_rd_ptr <= '0;
            tx_count  <= '0;
        end else begin
            if (tx_flush) begin
                tx_wr_ptr <= '0;
                tx_rd_ptr <= '0;
            end else begin
                tx_wr_ptr <= tx_wr_ptr + AW'(tx_push);
                tx_rd_ptr <= tx_rd_ptr + AW'(tx_pop);
            end
            tx_count <= next_count(tx_count, tx_flush, tx_push, tx_pop);
        end
    end

    // Receive queue pointers and count
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_wr_ptr <= '0;
            rx_rd_ptr <= '0;
            rx_count  <= '0;
        end else begin
            if (rx_flush) begin
                rx_wr_ptr <= '0;
                rx_rd_ptr <= '0;
            end else begin
                rx_wr_ptr <= rx_wr_ptr + AW'(rx_push);
                rx_rd_ptr <= rx_rd_ptr + AW'(rx_pop);
            end
            rx_count <= next_count(rx_count, rx_flush, rx_push, rx_pop);
        end
    end

    ufc_mem #(
        .WIDTH (8),
        .DEPTH (DEPTH)
    ) u_tx_mem (
        .i_clk     (i_clk),
        .i_rst_b   (i_rst_b),
        .i_wr_en   (tx_push),
        .i_wr_addr (tx_wr_ptr),
        .i_wr_data (wr_data[7:0]),
        .i_rd_addr (tx_rd_ptr),
        .o_rd_data (tx_head)
    );

    ufc_mem #(
        .WIDTH (8),
        .DEPTH (DEPTH)
    ) u_rx_mem (
        .i_clk     (i_clk),
        .i_rst_b   (i_rst_b),
        .i_wr_en   (rx_push),
        .i_wr_addr (rx_wr_ptr),
        .i_wr_data (i_rx_data),
        .i_rd_addr (rx_rd_ptr),
        .o_rd_data (rx_head)
    );

    // The registered read lags a pointer move by one cycle, so the head
    // byte is offered only once it has settled: half rate, no bubble logic
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_fresh <= 1'b0;
        end else begin
            tx_fresh <= (tx_count != '0) && !tx_pop && !tx_flush;
        end
    end

    assign o_tx_valid = tx_fresh && (tx_count != '0);
    assign o_tx_data  = tx_head;

    // Mode 1 receive request latches on trigger or timeout, holds to empty
    assign rx_req_set = (rx_count >= rx_trig) ||
                        (i_rx_timeout && rx_count != '0);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_req_held <= 1'b0;
        end else if (mode1 && rx_req_set) begin
            rx_req_held <= 1'b1;
        end else if (!mode1 || rx_count == '0) begin
            rx_req_held <= 1'b0;
        end
    end

    assign o_tx_request_n = mode1 ? tx_full : (tx_count != '0);
    assign o_rx_request_n = mode1 ? !rx_req_held : (rx_count == '0);

    assign o_rx_data_irq  = fifo_control.fifo_en ? (rx_count >= rx_trig)
                                        : (rx_count != '0);
    assign o_tx_empty_irq = fifo_control.fifo_en ? (tx_count < tx_trig)
                                        : (tx_count == '0);
    assign o_fifo_enabled = fifo_control.fifo_en;

    // Read channel: fixed latency so the memory read port can settle
    assign o_arready = (rd_state == ufc_pkg::RD_IDLE);
    assign rd_mapped = addr_hit(rd_addr, `UFC_OFF_FIFO_CTRL) ||
                       addr_hit(rd_addr, `UFC_OFF_TX_DATA) ||
                       addr_hit(rd_addr, `UFC_OFF_RX_DATA) ||
                       addr_hit(rd_addr, `UFC_OFF_STATUS);

    always_comb begin
        rd_mux = '0;
        if (addr_hit(rd_addr, `UFC_OFF_FIFO_CTRL)) begin
            // Flush bits are pulses and always read back as zero
            rd_mux[`UFC_FCR_RX_THR_LSB +: 2] = fifo_control.rx_thr;
            rd_mux[`UFC_FCR_TX_THR_LSB +: 2] = fifo_control.tx_thr;
            rd_mux[`UFC_FCR_DMA_MODE]        = fifo_control.dma_mode;
            rd_mux[`UFC_FCR_ENABLE]          = fifo_control.fifo_en;
        end else if (addr_hit(rd_addr, `UFC_OFF_RX_DATA)) begin
            rd_mux[7:0] = rx_hit ? rx_head : 8'h00;
        end else if (addr_hit(rd_addr, `UFC_OFF_STATUS)) begin
            rd_mux[CW-1:0]                        = rx_count;
            rd_mux[`UFC_ST_TX_CNT_LSB +: CW]      = tx_count;
            rd_mux[`UFC_ST_TX_REQ_N]              = o_tx_request_n;
            rd_mux[`UFC_ST_RX_REQ_N]              = o_rx_request_n;
            rd_mux[`UFC_ST_RX_IRQ]                = o_rx_data_irq;
            rd_mux[`UFC_ST_TX_IRQ]                = o_tx_empty_irq;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rd_state <= ufc_pkg::RD_IDLE;
            rd_addr  <= '0;
            rx_hit   <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata  <= '0;
            o_rresp  <= `UFC_RESP_OKAY;
        end else begin
            case (rd_state)
                ufc_pkg::RD_IDLE: begin
                    if (i_arvalid) begin
                        rd_addr  <= i_araddr;
                        rd_state <= ufc_pkg::RD_WAIT;
                    end
                end
                ufc_pkg::RD_WAIT: begin
                    // A byte counted now is already in memory
                    rx_hit   <= (rx_count != '0) && !rx_flush;
                    rd_state <= ufc_pkg::RD_DATA;
                end
                ufc_pkg::RD_DATA: begin
                    o_rdata  <= rd_mux;
                    o_rresp  <= rd_mapped ? `UFC_RESP_OKAY
                                          : `UFC_RESP_DECERR;
                    o_rvalid <= 1'b1;
                    rd_state <= ufc_pkg::RD_RESP;
                end
                ufc_pkg::RD_RESP: begin
                    if (i_rready) begin
                        o_rvalid <= 1'b0;
                        rd_state <= ufc_pkg::RD_IDLE;
                    end
                end
                default: begin
                    rd_state <= ufc_pkg::RD_IDLE;
                end
            endcase
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    a_tx_req_mode0: assert property (
        !mode1 |-> (o_tx_request_n == (tx_count != '0)))
        else $error("tx request wrong in mode 0");
    a_tx_req_release: assert property (
        (!mode1 && tx_count == '0 && tx_push && !tx_flush)
            |=> !mode1 |-> o_tx_request_n)
        else $error("tx request not released after write");
    a_tx_req_mode1: assert property (
        mode1 |-> (o_tx_request_n == (tx_count == CW'(DEPTH))))
        else $error("tx request wrong in mode 1");
    a_rx_req_mode0: assert property (
        !mode1 && rx_count != '0 |-> !o_rx_request_n)
        else $error("rx request high with data in mode 0");
    a_rx_req_hold: assert property (
        (mode1 && !o_rx_request_n && rx_count != '0 && !wr_fcr)
            ##1 (rx_count != '0 && mode1) |-> !o_rx_request_n)
        else $error("rx request dropped before empty");
    a_rx_req_timeout: assert property (
        (mode1 && !wr_fcr && i_rx_timeout && rx_count != '0 && !rx_pop)
            |=> !o_rx_request_n)
        else $error("rx request missed a timeout");
    a_rx_irq_rise: assert property (
        (fifo_control.fifo_en && rx_count == rx_trig - CW'(1) && rx_push && !rx_pop
            && !wr_fcr) |=> o_rx_data_irq)
        else $error("rx condition missing at trigger");
    a_rx_irq_fall: assert property (
        (fifo_control.fifo_en && rx_count == rx_trig && rx_pop && !rx_push
            && !wr_fcr) |=> !o_rx_data_irq)
        else $error("rx condition kept below trigger");
    a_rx_keep_fill: assert property (
        (fifo_control.fifo_en && rx_count >= rx_trig && rx_count < CW'(DEPTH)
            && !rx_flush) |-> o_rx_ready)
        else $error("rx queue refused bytes before full");
    a_tx_flush_empty: assert property (
        tx_flush |=> (tx_count == '0) ##1 $stable(fifo_control.fifo_en) [*1])
        else $error("tx flush left bytes");
    a_rx_flush_empty: assert property (
        rx_flush |=> (rx_count == '0))
        else $error("rx flush left bytes");
    a_fcr_guarded: assert property (
        (wr_fcr && !wr_data[`UFC_FCR_ENABLE])
            |=> $stable(fifo_control.rx_thr) && $stable(fifo_control.tx_thr)
                && $stable(fifo_control.dma_mode) && !fifo_control.fifo_en)
        else $error("control fields changed without enable");
    a_tx_irq_level: assert property (
        (fifo_control.fifo_en && tx_count == tx_trig && tx_pop && !tx_push
            && !wr_fcr) |=> o_tx_empty_irq)
        else $error("tx condition missing below trigger");

endmodule // ufc_top
`default_nettype wire

/* testbench/ufc_line_model.sv */
// Line-side model: sends receive bytes on command, takes transmit bytes
`timescale 1ns/100ps
`default_nettype none
module ufc_line_model (
    // Clock, reset and bench control
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_go,
    input  wire logic [5:0] i_n,
    input  wire logic       i_take,
    // Queue side
    input  wire logic       i_rx_ready,
    output logic            o_rx_valid,
    output logic      [7:0] o_rx_data,
    output logic            o_tx_take
);
    logic [5:0] left;
    logic [7:0] seq;
    assign o_rx_valid = (left != 6'h00);
    // Idle line shows the inverse, so a stale byte is never mistaken
    assign o_rx_data = o_rx_valid ? seq : ~seq;
    assign o_tx_take = i_take;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            left <= 6'h00;
            seq  <= 8'h00;
        end else if (i_go) begin
            left <= i_n;
        end else if (o_rx_valid && i_rx_ready) begin
            left <= left - 6'h01;
            seq  <= seq + 8'h01;
        end
    end
endmodule // ufc_line_model
`default_nettype wire

/* testbench/test_ufc_top.sv */
// Bench for the FIFO control block over AXI4-Lite
`timescale 1ns/100ps
`default_nettype none
module test_ufc_top;
    logic clk, rst_b, awv, awr, wv, wr, bv, bry, arv, arr, rv, rry;
    logic txv, tk, take, rxv, rxr, go, txq, rxq, rxi, txi, en, tmo;
    logic [7:0]  awa, ara, txd, rxd;
    logic [31:0] wd, rd, d;
    logic [1:0]  br, rr, r;
    logic [5:0]  cnt;
    int failures, num_checks, c, i;
    int rt[4] = '{8, 16, 24, 28};
    int tt[4] = '{16, 8, 24, 30};
    ufc_top u_dut (.i_clk(clk), .i_rst_b(rst_b),
        .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa),
        .i_wvalid(wv), .o_wready(wr), .i_wdata(wd), .i_wstrb(4'hF),
        .o_bvalid(bv), .i_bready(bry), .o_bresp(br),
        .i_arvalid(arv), .o_arready(arr), .i_araddr(ara),
        .o_rvalid(rv), .i_rready(rry), .o_rdata(rd), .o_rresp(rr),
        .o_tx_valid(txv), .o_tx_data(txd), .i_tx_take(take),
        .i_rx_valid(rxv), .i_rx_data(rxd), .o_rx_ready(rxr),
        .i_rx_timeout(tmo), .o_tx_request_n(txq), .o_rx_request_n(rxq),
        .o_rx_data_irq(rxi), .o_tx_empty_irq(txi), .o_fifo_enabled(en));
    ufc_line_model u_line (.i_clk(clk), .i_rst_b(rst_b), .i_go(go),
        .i_n(cnt), .i_take(tk), .i_rx_ready(rxr), .o_rx_valid(rxv),
        .o_rx_data(rxd), .o_tx_take(take));
    task automatic complete_run;
        $display("checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic bound(input int n);
        if (n >= 200) begin
            chk(1, 0);
            complete_run;
        end
    endtask
    // One task for both directions keeps the handshake rules in one place
    task automatic axi(input bit w, input logic [7:0] a, input logic [31:0] v);
        int n;
        bit ha, hw, hb;
        n = 0;
        hb = 0;
        @(posedge clk);
        if (w) {awv, wv, bry, awa, wd} <= {3'b111, a, v};
        else {arv, rry, ara} <= {2'b11, a};
        while (!hb && n < 200) begin
            @(negedge clk);
            ha = awv && awr || arv && arr;
            hw = wv && wr;
            hb = w ? bv : rv;
            d = rd;
            r = w ? br : rr;
            @(posedge clk);
            if (ha) {awv, arv} <= 2'b00;
            if (hw) wv <= 0;
            n++;
        end
        {bry, rry} <= 2'b00;
        bound(n);
        @(negedge clk);
    endtask
    task automatic send(input logic [5:0] k);
        int n;
        n = 0;
        @(posedge clk);
        {cnt, go} <= {k, 1'b1};
        @(posedge clk);
        go <= 0;
        do begin
            @(negedge clk);
            n++;
        end while (u_line.left != 0 && n < 200);
        bound(n);
    endtask
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        {rst_b, awv, wv, bry, arv, rry, go, tk, tmo, awa, ara, wd, cnt} = '0;
        repeat (20) @(posedge clk);
        rst_b <= 1;
        axi(0, 8'h0C, 0);
        chk(d, 32'h000A_0000);
        axi(0, 8'h00, 0);
        chk(d, 0);
        axi(0, 8'h10, 0);
        chk(r, 3);
        axi(1, 8'h10, 0);
        chk(r, 3);
        $display("test reset and decode done");
        for (c = 0; c < 4; c++) begin
            axi(1, 8'h00, 32'(c * 64 + 3));
            chk(rxq, 1);
            send(6'(rt[c] - 1));
            chk(rxi, 0);
            send(1);
            chk(rxi, 1);
        end
        chk(rxq, 0);
        send(4);
        chk(rxr, 0);
        axi(0, 8'h0C, 0);
        chk(d[5:0], 32);
        axi(1, 8'h00, 32'h0B);
        send(7);
        chk(rxq, 1);
        send(1);
        // The mode 1 request is latched, so it follows the count by a cycle
        @(negedge clk);
        chk(rxq, 0);
        axi(0, 8'h08, 0);
        chk(d, 32'h50);
        chk({rxq, rxi}, 0);
        repeat (7) axi(0, 8'h08, 0);
        chk(rxq, 1);
        send(1);
        chk(rxq, 1);
        @(posedge clk) tmo <= 1;
        @(posedge clk) tmo <= 0;
        @(negedge clk);
        chk(rxq, 0);
        axi(0, 8'h08, 0);
        chk(d, 32'h58);
        chk(rxq, 1);
        $display("test receive done");
        for (c = 0; c < 4; c++) begin
            axi(1, 8'h00, 32'(c * 16 + 5));
            chk(txq, 0);
            for (i = 1; i < tt[c]; i++) axi(1, 8'h04, i);
            chk({txq, txi}, 3);
            axi(1, 8'h04, 0);
            chk(txi, 0);
        end
        axi(1, 8'h00, 32'h39);
        chk(txq, 0);
        repeat (2) axi(1, 8'h04, 0);
        chk(txq, 1);
        chk({txv, txd}, 32'h101);
        @(posedge clk) tk <= 1;
        @(posedge clk) tk <= 0;
        @(negedge clk);
        chk(txq, 0);
        axi(1, 8'h00, 32'h08);
        chk(en, 0);
        axi(0, 8'h00, 0);
        chk({d, txq}, 32'h70);
        $display("test transmit done");
        complete_run;
    end
endmodule // test_ufc_top
`default_nettype wire
